// file: hw/rtc_nvram_cfg.svh
`ifndef RTC_NVRAM_CFG_SVH
`define RTC_NVRAM_CFG_SVH
// register byte addresses at the top of the 32k space
`define ADDR_W           15
`define ADDR_CONTROL     15'h7ff8
`define ADDR_SECONDS     15'h7ff9
`define ADDR_MINUTES     15'h7ffa
`define ADDR_HOURS       15'h7ffb
`define ADDR_WEEKDAY     15'h7ffc
`define ADDR_DAY_MONTH   15'h7ffd
`define ADDR_MONTH       15'h7ffe
`define ADDR_YEAR        15'h7fff
// field positions
`define BIT_WRITE_HALT   7
`define BIT_READ_HALT    6
`define BIT_OSC_STOP     7
`define BIT_FREQ_TEST    6
// field masks of used bits per register
`define MASK_SECONDS     8'h7f
`define MASK_MINUTES     8'h7f
`define MASK_HOURS       8'h3f
`define MASK_WEEKDAY     8'h07
`define MASK_DAY_MONTH   8'h3f
`define MASK_MONTH       8'h1f
`define MASK_YEAR        8'hff
// timing: system clock and derived rates
`define CLK_HZ           100000000
`define TEST_HZ          512
`define TICK_1HZ_CYC     (`CLK_HZ / 1)
`define TICK_TEST_CYC    (`CLK_HZ / (2 * `TEST_HZ))
`endif

// file: hw/rtc_nvram_pkg.sv
`default_nettype none
package rtc_nvram_pkg;
  // bus access mode decoded from the strobes
  typedef enum logic [1:0] {
    MODE_DESELECT,
    MODE_READ,
    MODE_WRITE
  } access_mode_t;
  // one full time-of-day set, bcd
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] wday;
    logic [7:0] mday;
    logic [7:0] mon;
    logic [7:0] year;
  } time_set_t;
endpackage
`default_nettype wire

// file: hw/nvram_mem.sv
`default_nettype none
// byte memory with registered read data
module nvram_mem #(
  parameter int ADDR_W = 15
) (
  input  wire logic              clk_sys,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wr_data,
  output logic      [7:0]        rd_data_q
);
  logic [7:0] mem [0:(1<<ADDR_W)-1];
  // contents are kept: no reset, battery backed in the real part
  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
    begin
      mem[addr] <= wr_data;
    end
    rd_data_q <= mem[addr];
  end
endmodule // nvram_mem
`default_nettype wire

// file: hw/bcd_time_counter.sv
`default_nettype none
`include "rtc_nvram_cfg.svh"
// bcd calendar counter; advances one second per tick
module bcd_time_counter (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire logic                  tick,
  input  wire logic                  load,
  input  wire rtc_nvram_pkg::time_set_t load_val,
  output var rtc_nvram_pkg::time_set_t cnt_q
);
  import rtc_nvram_pkg::*;
  time_set_t cnt_d;

  // bcd increment with wrap to a floor value
  function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] last,
                                         input logic [7:0] first);
    if (v >= last) return first;
    if (v[3:0] >= 4'h9) return {v[7:4] + 4'h1, 4'h0};
    return {v[7:4], v[3:0] + 4'h1};
  endfunction

  // last day of month with leap years valid to 2099
  function automatic logic [7:0] month_end(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    leap = ((yr[7:4] * 4'd10 + yr[3:0]) % 8'd4) == 8'd0;
    case (mon)
      8'h02:   return leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction

  // carry chain through the calendar fields
  always_comb
  begin
    cnt_d = cnt_q;
    if (load)
    begin
      cnt_d = load_val;
    end
    else if (tick)
    begin
      cnt_d.sec = bcd_inc(cnt_q.sec, 8'h59, 8'h00);
      if (cnt_q.sec == 8'h59)
      begin
        cnt_d.min = bcd_inc(cnt_q.min, 8'h59, 8'h00);
        if (cnt_q.min == 8'h59)
        begin
          cnt_d.hour = bcd_inc(cnt_q.hour, 8'h23, 8'h00);
          if (cnt_q.hour == 8'h23)
          begin
            cnt_d.wday = bcd_inc(cnt_q.wday, 8'h07, 8'h01);
            cnt_d.mday = bcd_inc(cnt_q.mday, month_end(cnt_q.mon, cnt_q.year), 8'h01);
            if (cnt_q.mday >= month_end(cnt_q.mon, cnt_q.year))
            begin
              cnt_d.mon = bcd_inc(cnt_q.mon, 8'h12, 8'h01);
              if (cnt_q.mon == 8'h12)
              begin
                cnt_d.year = bcd_inc(cnt_q.year, 8'h99, 8'h00);
              end
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cnt_q <= '{sec: 8'h00, min: 8'h00, hour: 8'h00, wday: 8'h01,
                 mday: 8'h01, mon: 8'h01, year: 8'h00};
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end
endmodule // bcd_time_counter
`default_nettype wire

// file: hw/bytewide_rtc_nvram_access.sv
// Notes on behaviour
// - read-halt bit set stops copying counters into visible registers
// - during read halt visible registers hold the captured time
// - counters keep counting while either halt is set
// - clearing read halt refreshes all visible registers together within a second
// - write halt freezes updates; clearing it loads written values into counters
// - seconds msb set stops the oscillator, clear lets it run
// - frequency test with oscillator running toggles seconds lsb at 512 hz
// - held seconds read with frequency test shows data line 0 toggling
// - eight registers 7ff8..7fff, control then seven bcd time registers, 24-hour format
// - chip select low, write enable high is read mode, ripple-through
// - data driven only with select and output enable low in read
// - select and write enable low is write mode; address held stable
// - write enable low stops read drive even with output enable low
// - power fail inhibits chip select, blocking every access
// - power fail output low until supply returns to nominal
// - on battery, timekeeping and memory contents are kept
`default_nettype none
`include "rtc_nvram_cfg.svh"
module bytewide_rtc_nvram_access #(
  parameter int ADDR_W   = `ADDR_W,
  parameter int TICK_CYC = `TICK_1HZ_CYC,
  parameter int TEST_CYC = `TICK_TEST_CYC
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              chip_sel_n,
  input  wire logic              out_en_n,
  input  wire logic              wr_en_n,
  input  wire logic [7:0]        dq_in,
  output logic      [7:0]        dq_out,
  output logic                   dq_oe_n,
  input  wire logic              supply_low,
  input  wire logic              supply_below_batt,
  output logic                   power_fail_out_n,
  output logic                   on_battery
);
  import rtc_nvram_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  // address and data share the strobes' two stages, so all of them stay in step
  logic [ADDR_W-1:0] addr_m_q, addr_s_q;
  logic [7:0]        dqi_m_q,  dqi_s_q;
  logic [4:0]        ctl_m_q,  ctl_s_q;
  always_ff @(posedge clk_sys)
  begin
    addr_m_q <= addr;
    addr_s_q <= addr_m_q;
    dqi_m_q  <= dq_in;
    dqi_s_q  <= dqi_m_q;
    ctl_m_q  <= {supply_below_batt, supply_low, wr_en_n, out_en_n, chip_sel_n};
    ctl_s_q  <= ctl_m_q;
  end
  logic cs_n_s, oe_n_s, we_n_s, low_s, batt_s;
  assign {batt_s, low_s, we_n_s, oe_n_s, cs_n_s} = ctl_s_q;

  //////////////////////////////////////////////////////////////////////////////
  // mode decode
  function automatic access_mode_t decode_mode(input logic cs_n, input logic we_n,
                                               input logic pf);
    if (cs_n || pf) return MODE_DESELECT;
    if (!we_n) return MODE_WRITE;
    return MODE_READ;
  endfunction

  function automatic logic is_clock_addr(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:3] == {(ADDR_W-3){1'b1}};
  endfunction

  access_mode_t mode, mode_prev_q;
  assign mode = decode_mode(cs_n_s, we_n_s, low_s);

  //////////////////////////////////////////////////////////////////////////////
  // state
  // control bits and the visible copies of the time registers
  logic              wr_halt_q, wr_halt_d, rd_halt_q, rd_halt_d;
  logic              osc_stop_q, osc_stop_d, ftest_q, ftest_d;
  time_set_t         vis_q, vis_d;
  // last address and data seen while the write strobes were active
  logic [ADDR_W-1:0] wr_addr_q, wr_addr_d;
  logic [7:0]        wr_data_q, wr_data_d;
  // rate dividers and the counter load strobe
  logic [31:0]       tick_cnt_q, tick_cnt_d, test_cnt_q, test_cnt_d;
  logic              ft_lsb_q, ft_lsb_d;
  logic              cnt_load_q, cnt_load_d;
  logic              tick;
  // next values of the registered pin outputs
  logic [7:0]        dq_out_d;
  logic              dq_oe_n_d, pf_n_d, batt_d;
  // memory and counter glue
  logic              ram_we, commit;
  time_set_t         cnt_now;
  logic [7:0]        ram_rd;

  // end of write: mode leaves write, taking the last sampled data;
  // a write cut short by power fail is dropped rather than committed
  assign commit = (mode_prev_q == MODE_WRITE) && (mode != MODE_WRITE) && !low_s;
  assign ram_we = commit && !is_clock_addr(wr_addr_q);

  //////////////////////////////////////////////////////////////////////////////
  // one-second and test-rate dividers; oscillator stop gates both
  always_comb
  begin
    tick       = 1'b0;
    tick_cnt_d = tick_cnt_q;
    test_cnt_d = test_cnt_q;
    ft_lsb_d   = ft_lsb_q;
    if (!osc_stop_q)
    begin
      if (tick_cnt_q >= 32'(TICK_CYC - 1))
      begin
        tick_cnt_d = 32'h0;
        tick       = 1'b1;
      end
      else
      begin
        tick_cnt_d = tick_cnt_q + 32'h1;
      end
      if (test_cnt_q >= 32'(TEST_CYC - 1))
      begin
        test_cnt_d = 32'h0;
        ft_lsb_d   = !ft_lsb_q;
      end
      else
      begin
        test_cnt_d = test_cnt_q + 32'h1;
      end
    end
    // a freshly set clock starts a full second
    if (cnt_load_q)
    begin
      tick_cnt_d = 32'h0;
    end
  end

  // divider state
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      tick_cnt_q <= 32'h0;
      test_cnt_q <= 32'h0;
      ft_lsb_q   <= 1'b0;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_d;
      test_cnt_q <= test_cnt_d;
      ft_lsb_q   <= ft_lsb_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register file: control bits, visible copies, halt handling
  always_comb
  begin
    wr_halt_d  = wr_halt_q;
    rd_halt_d  = rd_halt_q;
    osc_stop_d = osc_stop_q;
    ftest_d    = ftest_q;
    vis_d      = vis_q;
    cnt_load_d = 1'b0;
    wr_addr_d  = wr_addr_q;
    wr_data_d  = wr_data_q;
    if (mode == MODE_WRITE)
    begin
      wr_addr_d = addr_s_q;
      wr_data_d = dqi_s_q;
    end
    // visible copies follow counters only while no halt is set and no load is pending
    if (!rd_halt_q && !wr_halt_q && !cnt_load_q)
    begin
      vis_d = cnt_now;
    end
    // clock register writes take effect the cycle after the strobes go inactive
    if (commit && is_clock_addr(wr_addr_q))
    begin
      case (wr_addr_q[2:0])
        3'd0:
        begin
          rd_halt_d = wr_data_q[`BIT_READ_HALT];
          wr_halt_d = wr_data_q[`BIT_WRITE_HALT];
          if (wr_halt_q && !wr_data_q[`BIT_WRITE_HALT])
          begin
            cnt_load_d = 1'b1;
          end
        end
        3'd1:
        begin
          vis_d.sec  = wr_data_q & `MASK_SECONDS;
          osc_stop_d = wr_data_q[`BIT_OSC_STOP];
        end
        3'd2: vis_d.min  = wr_data_q & `MASK_MINUTES;
        3'd3: vis_d.hour = wr_data_q & `MASK_HOURS;
        3'd4:
        begin
          vis_d.wday = wr_data_q & `MASK_WEEKDAY;
          ftest_d    = wr_data_q[`BIT_FREQ_TEST];
        end
        3'd5: vis_d.mday = wr_data_q & `MASK_DAY_MONTH;
        3'd6: vis_d.mon  = wr_data_q & `MASK_MONTH;
        3'd7: vis_d.year = wr_data_q;
        default: vis_d = vis_q;
      endcase
    end
  end

  // register file state
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      wr_halt_q   <= 1'b0;
      rd_halt_q   <= 1'b0;
      osc_stop_q  <= 1'b0;
      ftest_q     <= 1'b0;
      vis_q       <= '{sec: 8'h00, min: 8'h00, hour: 8'h00, wday: 8'h01,
                       mday: 8'h01, mon: 8'h01, year: 8'h00};
      wr_addr_q   <= '0;
      wr_data_q   <= 8'h00;
      cnt_load_q  <= 1'b0;
      mode_prev_q <= MODE_DESELECT;
    end
    else
    begin
      wr_halt_q   <= wr_halt_d;
      rd_halt_q   <= rd_halt_d;
      osc_stop_q  <= osc_stop_d;
      ftest_q     <= ftest_d;
      vis_q       <= vis_d;
      wr_addr_q   <= wr_addr_d;
      wr_data_q   <= wr_data_d;
      cnt_load_q  <= cnt_load_d;
      mode_prev_q <= mode;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data path and power status
  always_comb
  begin
    pf_n_d    = !low_s;
    batt_d    = batt_s;
    dq_oe_n_d = !((mode == MODE_READ) && !oe_n_s);
    dq_out_d  = ram_rd;
    if (is_clock_addr(addr_s_q))
    begin
      case (addr_s_q[2:0])
        3'd0: dq_out_d = {wr_halt_q, rd_halt_q, 6'h00};
        3'd1: dq_out_d = {osc_stop_q, vis_q.sec[6:1],
                          (ftest_q && !osc_stop_q) ? ft_lsb_q : vis_q.sec[0]};
        3'd2: dq_out_d = vis_q.min;
        3'd3: dq_out_d = vis_q.hour;
        3'd4: dq_out_d = {1'b0, ftest_q, 3'b000, vis_q.wday[2:0]};
        3'd5: dq_out_d = vis_q.mday;
        3'd6: dq_out_d = vis_q.mon;
        3'd7: dq_out_d = vis_q.year;
        default: dq_out_d = 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered pin outputs
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      dq_out           <= 8'h00;
      dq_oe_n          <= 1'b1;
      power_fail_out_n <= 1'b1;
      on_battery       <= 1'b0;
    end
    else
    begin
      dq_out           <= dq_out_d;
      dq_oe_n          <= dq_oe_n_d;
      power_fail_out_n <= pf_n_d;
      on_battery       <= batt_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // counters run regardless of halts; loaded when write halt clears
  bcd_time_counter u_counter (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .tick     (tick),
    .load     (cnt_load_q),
    .load_val (vis_q),
    .cnt_q    (cnt_now)
  );

  nvram_mem #(.ADDR_W(ADDR_W)) u_mem (
    .clk_sys   (clk_sys),
    .wr_en     (ram_we),
    .addr      (ram_we ? wr_addr_q : addr_s_q),
    .wr_data   (wr_data_q),
    .rd_data_q (ram_rd)
  );
endmodule // bytewide_rtc_nvram_access
`default_nettype wire

// file: sim/rtc_access_sva.sv
`default_nettype none
// port checker for the byte-wide clock and memory block
module rtc_access_sva #(
  parameter int ADDR_W = 15
) (
  input wire logic              clk_sys,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic              chip_sel_n,
  input wire logic              out_en_n,
  input wire logic              wr_en_n,
  input wire logic [7:0]        dq_in,
  input wire logic [7:0]        dq_out,
  input wire logic              dq_oe_n,
  input wire logic              supply_low,
  input wire logic              supply_below_batt,
  input wire logic              power_fail_out_n,
  input wire logic              on_battery
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  // data pins and access modes
  deselect_hiz_a: assert property (chip_sel_n [*5] |-> dq_oe_n)
    else $error("data driven while deselected");
  outen_hiz_a: assert property (out_en_n [*5] |-> dq_oe_n)
    else $error("data driven with output enable high");
  write_hiz_a: assert property (!wr_en_n [*5] |-> dq_oe_n)
    else $error("data driven during write");
  pfail_hiz_a: assert property (supply_low [*5] |-> dq_oe_n)
    else $error("access allowed in power fail");
  read_drive_a: assert property (
    (!chip_sel_n && !out_en_n && wr_en_n && !supply_low) [*6] |-> !dq_oe_n)
    else $error("read data not driven");
  ////////////////////////////////////////////////////////////////////////////
  // power fail output and battery switchover
  pfo_set_a: assert property ($rose(supply_low) |-> ##[1:4] !power_fail_out_n)
    else $error("power fail output late");
  pfo_hold_a: assert property (supply_low [*5] |-> !power_fail_out_n)
    else $error("power fail output released early");
  pfo_clear_a: assert property (!supply_low [*5] |-> power_fail_out_n)
    else $error("power fail output stuck");
  batt_on_a: assert property ($rose(supply_below_batt) |-> ##[1:4] on_battery)
    else $error("battery switch late");
  batt_off_a: assert property (!supply_below_batt [*5] |-> !on_battery)
    else $error("battery switch stuck");
endmodule // rtc_access_sva

bind bytewide_rtc_nvram_access rtc_access_sva #(.ADDR_W(ADDR_W)) rtc_access_sva_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .chip_sel_n(chip_sel_n),
  .out_en_n(out_en_n), .wr_en_n(wr_en_n), .dq_in(dq_in), .dq_out(dq_out),
  .dq_oe_n(dq_oe_n), .supply_low(supply_low), .supply_below_batt(supply_below_batt),
  .power_fail_out_n(power_fail_out_n), .on_battery(on_battery));
`default_nettype wire

// file: sim/rtc_host_model.sv
`default_nettype none
// host bus master running asynchronous sram cycles
module rtc_host_model #(
  parameter int ADDR_W = 15
) (
  input  wire logic              clk_sys,
  input  wire logic [7:0]        dq_out,
  input  wire logic              dq_oe_n,
  output logic      [ADDR_W-1:0] addr,
  output logic                   chip_sel_n,
  output logic                   out_en_n,
  output logic                   wr_en_n,
  output logic      [7:0]        dq_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       drv;
  logic [7:0] wd;
  logic [7:0] float_q;
  // pin level: host data, else device data, else a pattern that keeps changing
  assign dq_in = drv ? wd : (!dq_oe_n ? dq_out : float_q);
  always @(posedge clk_sys) float_q <= ~dq_in;
  initial
  begin
    addr = '0;
    chip_sel_n = 1'b1;
    out_en_n = 1'b1;
    wr_en_n = 1'b1;
    drv = 1'b0;
    wd = 8'h00;
    float_q = 8'h00;
  end
  // write cycle; address and data held past the end of write
  task automatic write(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    addr = a;
    wd = d; // callers keep unused bits zero
    drv = 1'b1;
    chip_sel_n = 1'b0;
    wr_en_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    chip_sel_n = 1'b1;
    wr_en_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    drv = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask
  // read cycle left open until close_read
  task automatic open_read(input logic [ADDR_W-1:0] a);
    @(negedge clk_sys);
    addr = a;
    chip_sel_n = 1'b0;
    out_en_n = 1'b0;
    repeat (7) @(negedge clk_sys);
  endtask
  task automatic close_read();
    chip_sel_n = 1'b1;
    out_en_n = 1'b1;
    repeat (4) @(negedge clk_sys);
  endtask
endmodule // rtc_host_model
`default_nettype wire

// file: sim/bytewide_rtc_nvram_access_tb_top.sv
`default_nettype none
`include "rtc_nvram_cfg.svh"
module bytewide_rtc_nvram_access_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk_sys, rst_n, chip_sel_n, out_en_n, wr_en_n, dq_oe_n;
  logic              supply_low, supply_below_batt, power_fail_out_n, on_battery;
  logic [14:0]       addr;
  logic [7:0]        dq_in, dq_out, v, sa, sb;
  logic [14:0]       ra[8];
  logic [7:0]        rv[8];
  logic [7:0]        ld[7] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
  logic [7:0]        ex[7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
  int                errors, n_tests, seed, n;
  bytewide_rtc_nvram_access #(.TICK_CYC(100), .TEST_CYC(5)) bytewide_rtc_nvram_access_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .chip_sel_n(chip_sel_n),
    .out_en_n(out_en_n), .wr_en_n(wr_en_n), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n), .supply_low(supply_low), .supply_below_batt(supply_below_batt),
    .power_fail_out_n(power_fail_out_n), .on_battery(on_battery));
  rtc_host_model rtc_host_model_i (
    .clk_sys(clk_sys), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .addr(addr),
    .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .wr_en_n(wr_en_n), .dq_in(dq_in));
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // bcd byte to a plain number
  function automatic int bcd(input logic [7:0] b);
    return b[7:4] * 10 + b[3:0];
  endfunction
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    rtc_host_model_i.write(a, d);
  endtask
  task automatic rd(input logic [14:0] a, output logic [7:0] d);
    rtc_host_model_i.open_read(a);
    check({7'h0, dq_oe_n}, 8'h00);
    d = dq_out;
    rtc_host_model_i.close_read();
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // watchdog well beyond the expected run of about 1700 cycles
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    report_and_stop();
  end
  initial
  begin
    seed = 32'h1fcd;
    errors = 0;
    n_tests = 0;
    rst_n = 1'b0;
    supply_low = 1'b0;
    supply_below_batt = 1'b0;
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    // random memory bytes, the last just under the clock registers
    for (int i = 0; i < 8; i++)
    begin
      ra[i] = 15'(i * 1024) + 15'($random(seed) & 32'h3ff);
      rv[i] = 8'($random(seed));
    end
    ra[7] = 15'h7ff7;
    for (int i = 0; i < 8; i++) wr(ra[i], rv[i]);
    for (int i = 0; i < 8; i++)
    begin
      rd(ra[i], v);
      check(v, rv[i]);
    end
    // write entered while a read drives the pins
    rtc_host_model_i.open_read(ra[0]);
    wr(ra[0], 8'h5a);
    rtc_host_model_i.close_read();
    rd(ra[0], v);
    check(v, 8'h5a);
    $display("test memory done");
    // load the last second of a year, let it roll over, then read the new year under read halt
    wr(`ADDR_CONTROL, 8'h80);
    for (int i = 0; i < 7; i++) wr(15'(`ADDR_SECONDS + i), ld[i]);
    wr(`ADDR_CONTROL, 8'h00);
    repeat (110) @(negedge clk_sys);
    wr(`ADDR_CONTROL, 8'h40);
    rd(`ADDR_CONTROL, v);
    check(v, 8'h40);
    for (int i = 0; i < 7; i++)
    begin
      rd(15'(`ADDR_SECONDS + i), v);
      if (i == 0)
        sa = v;
      if (i == 0)
        check({7'h0, v <= 8'h01}, 8'h01);
      else
        check(v, ex[i]);
    end
    repeat (250) @(negedge clk_sys);
    rd(`ADDR_SECONDS, v);
    check(v, sa);
    wr(`ADDR_CONTROL, 8'h00);
    repeat (200) @(negedge clk_sys);
    wr(`ADDR_CONTROL, 8'h40);
    rd(`ADDR_SECONDS, sb);
    n = bcd(sb) - bcd(sa);
    check({7'h0, n >= 4 && n <= 8}, 8'h01);
    $display("test halts done");
    // stopped oscillator keeps the seconds still
    wr(`ADDR_CONTROL, 8'h80);
    wr(`ADDR_SECONDS, 8'h90);
    wr(`ADDR_CONTROL, 8'h00);
    repeat (300) @(negedge clk_sys);
    rd(`ADDR_SECONDS, v);
    check(v, 8'h90);
    // restart with frequency test and watch data line 0 on a held read
    wr(`ADDR_CONTROL, 8'h80);
    wr(`ADDR_SECONDS, 8'h10);
    wr(`ADDR_WEEKDAY, 8'h41);
    wr(`ADDR_CONTROL, 8'h00);
    rd(`ADDR_WEEKDAY, v);
    check(v, 8'h41);
    rtc_host_model_i.open_read(`ADDR_SECONDS);
    n = 0;
    sa = dq_out;
    repeat (50)
    begin
      @(negedge clk_sys);
      n += (dq_out[0] !== sa[0]);
      sa = dq_out;
    end
    rtc_host_model_i.close_read();
    check({7'h0, n >= 9 && n <= 11}, 8'h01);
    $display("test oscillator done");
    // power fail refuses a write and a read, battery keeps the memory
    supply_low = 1'b1;
    repeat (5) @(negedge clk_sys);
    check({7'h0, power_fail_out_n}, 8'h00);
    wr(ra[1], ~rv[1]);
    rtc_host_model_i.open_read(ra[1]);
    check({7'h0, dq_oe_n}, 8'h01);
    rtc_host_model_i.close_read();
    supply_below_batt = 1'b1;
    repeat (5) @(negedge clk_sys);
    check({7'h0, on_battery}, 8'h01);
    supply_below_batt = 1'b0;
    supply_low = 1'b0;
    repeat (5) @(negedge clk_sys);
    check({6'h0, power_fail_out_n, on_battery}, 8'h02);
    rd(ra[1], v);
    check(v, rv[1]);
    $display("test power fail done");
    report_and_stop();
  end
endmodule // bytewide_rtc_nvram_access_tb_top
`default_nettype wire
